// file: logic/ftp_pkg.sv
// Constants, types and helpers shared by the frequency protection block.
// Assumes a single 25 MHz clock and AHB-Lite register access.
package ftp_pkg;
	// Clock and measurement range
	localparam int CLK_HZ  = 25_000_000;
	localparam int FMIN_HZ = 40;
	localparam int FMAX_HZ = 70;
	localparam int PW      = 21;
	localparam int SW      = 16;
	localparam int FW      = 17;
	localparam int DVW     = 36;
	localparam logic [PW-1:0] PER_MAX = PW'(CLK_HZ / FMIN_HZ);
	localparam logic [PW-1:0] PER_MIN = PW'(CLK_HZ / FMAX_HZ);
	localparam logic [PW-1:0] PER_LIM = PW'(CLK_HZ / FMIN_HZ + 1);
	// Clock cycles per second times millihertz per hertz
	localparam logic [DVW-1:0] FREQ_K = DVW'(64'(CLK_HZ) * 64'd1000);
	localparam logic [5:0]     DIV_STEPS = 6'h24;
	// Qualification counts
	localparam logic [2:0] ACCEPT_N = 3'h4;
	localparam logic [2:0] DROP_N   = 3'h4;
	localparam logic [2:0] START_N  = 3'h5;
	// Hysteresis and voltage reset ratio (4/5)
	localparam logic [FW:0]  HYST_MHZ = 18'h00065;
	localparam logic [19:0]  DROP_NUM = 20'h00004;
	localparam logic [19:0]  DROP_DEN = 20'h00005;
	// Trip delay range in milliseconds
	localparam logic [15:0] DELAY_MIN_MS = 16'h008C;
	localparam logic [15:0] DELAY_MAX_MS = 16'hEA60;
	// Register reset values
	localparam logic [FW-1:0] SFREQ_RST = 17'h0C738;
	localparam logic [15:0]   UPICK_RST = 16'h3999;
	localparam logic [15:0]   DELAY_RST = 16'h00C8;
	// Register byte addresses
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_SFREQ = 8'h04;
	localparam logic [7:0] A_UPICK = 8'h08;
	localparam logic [7:0] A_DELAY = 8'h0C;
	localparam logic [7:0] A_STATE = 8'h10;
	localparam logic [7:0] A_FREQ  = 8'h14;
	localparam logic [7:0] A_EVST  = 8'h18;
	localparam logic [7:0] A_EVMSK = 8'h1C;
	// Event bit positions
	localparam int EV_ST_ON  = 0;
	localparam int EV_ST_OFF = 1;
	localparam int EV_TR_ON  = 2;
	localparam int EV_TR_OFF = 3;

	typedef struct packed {
		logic chan4;
		logic start_only;
		logic over;
		logic enable;
	} ftp_ctrl_t;

	typedef struct packed {
		logic            busy;
		logic            done;
		logic [5:0]      cnt;
		logic [PW:0]     rem;
		logic [DVW-1:0]  q;
		logic [PW-1:0]   dv;
	} ftp_div_st_t;

	typedef struct packed {
		logic            hready;
		logic            hresp;
		logic [31:0]     hrdata;
		logic            rd_pend;
		logic            wr_pend;
		logic [7:0]      addr;
		ftp_ctrl_t       ctrl;
		logic [FW-1:0]   sfreq;
		logic [15:0]     upick;
		logic [15:0]     delay;
		logic [3:0]      ev_stat;
		logic [3:0]      ev_mask;
		logic            irq;
		logic            blk_s1;
		logic            blk_s2;
		logic            seen;
		logic            sgn_prev;
		logic [PW-1:0]   rise_age;
		logic [PW-1:0]   fall_age;
		logic [PW-1:0]   p_rise;
		logic [PW-1:0]   p_fall;
		logic [PW-1:0]   wd;
		logic [15:0]     peak;
		logic            volt_ok;
		logic            div_go;
		logic            div_valid;
		logic [2:0]      vcnt;
		logic [2:0]      icnt;
		logic            accepted;
		logic [FW-1:0]   freq;
		logic [2:0]      bcnt;
		logic            start;
		logic            trip;
		logic [15:0]     prescale;
		logic [15:0]     msec;
	} ftp_state_t;

	// Saturating increment of a small counter
	function automatic logic [2:0] cnt_inc(logic [2:0] c, logic [2:0] lim);
		cnt_inc = (c >= lim) ? lim : 3'(c + 3'h1);
	endfunction : cnt_inc

	// Saturating increment of a period age counter
	function automatic logic [PW-1:0] age_inc(logic [PW-1:0] a,
		logic [PW-1:0] lim);
		age_inc = (a >= lim) ? lim : PW'(a + 1'b1);
	endfunction : age_inc

	// Period lies inside the measurable band
	function automatic logic per_ok(logic [PW-1:0] p, logic [PW-1:0] lo,
		logic [PW-1:0] hi);
		per_ok = (p >= lo) && (p <= hi);
	endfunction : per_ok
endpackage : ftp_pkg

// file: logic/ftp_div.sv
// Sequential restoring divider: quotient of dividend over divisor.
// Assumes go is a one-cycle pulse and divisor is never zero.
`timescale 1ns/1ps
`default_nettype none
module ftp_div import ftp_pkg::*; (
	// Clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// Request
	input  wire logic             go,
	input  wire logic [DVW-1:0]   dividend,
	input  wire logic [PW-1:0]    divisor,
	// Answer
	output logic                  done,
	output logic [DVW-1:0]        quot
);
	ftp_div_st_t st;
	ftp_div_st_t n;

	// One quotient bit per cycle
	always_comb begin
		logic [PW:0]    r;
		logic [DVW-1:0] qq;
		r  = '0;
		qq = '0;
		n = st;
		n.done = 1'b0;
		if (go) begin
			n.busy = 1'b1;
			n.cnt  = '0;
			n.rem  = '0;
			n.q    = dividend;
			n.dv   = divisor;
		end else if (st.busy) begin
			r  = {st.rem[PW-1:0], st.q[DVW-1]};
			qq = {st.q[DVW-2:0], 1'b0};
			if (r >= {1'b0, st.dv}) begin
				r     = r - {1'b0, st.dv};
				qq[0] = 1'b1;
			end
			n.rem = r;
			n.q   = qq;
			n.cnt = 6'(st.cnt + 6'h01);
			if (n.cnt == DIV_STEPS) begin
				n.busy = 1'b0;
				n.done = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			st <= '0;
		else
			st <= n;
	end

	assign done = st.done;
	assign quot = st.q;
endmodule : ftp_div
`default_nettype wire

// file: logic/ftp_top.sv
// Frequency threshold protection with AHB-Lite registers and event irq.
// Assumes sample_valid, ch1_sample and ch4_sample come from hclk logic;
// block_input is an asynchronous pin.
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ftp_top import ftp_pkg::*; #(
	parameter int MS_CYCLES = CLK_HZ / 1000,
	parameter int CLK_RATE  = CLK_HZ
) (
	// Clock and reset
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic                       hresp,
	output logic [31:0]                hrdata,
	// Voltage samples
	input  wire logic                  sample_valid,
	input  wire logic signed [SW-1:0]  ch1_sample,
	input  wire logic signed [SW-1:0]  ch4_sample,
	// Binary input and outputs
	input  wire logic                  block_input,
	output logic                       general_start_out,
	output logic                       general_trip_out,
	output logic                       irq
);
	ftp_state_t      st;
	ftp_state_t      n;
	logic            res_done;
	logic [DVW-1:0]  res_quot;
	logic [PW:0]     per_sum;
	logic [PW-1:0]   per_mean;
	logic            beyond;
	logic            run;

	// Period band and divider constant follow the clock rate
	localparam logic [PW-1:0]  P_MAX = PW'(CLK_RATE / FMIN_HZ);
	localparam logic [PW-1:0]  P_MIN = PW'(CLK_RATE / FMAX_HZ);
	localparam logic [PW-1:0]  P_LIM = PW'(CLK_RATE / FMIN_HZ + 1);
	localparam logic [DVW-1:0] F_K   = DVW'(FREQ_K / CLK_HZ * CLK_RATE);

	// Mean of rising and falling periods feeds the divider
	assign per_sum  = {1'b0, st.p_rise} + {1'b0, st.p_fall};
	assign per_mean = (per_sum[PW:1] == '0) ? PW'(1) : per_sum[PW:1];

	ftp_div u_div (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.go       (st.div_go),
		.dividend (F_K),
		.divisor  (per_mean),
		.done     (res_done),
		.quot     (res_quot)
	);

	// Register read multiplexer
	function automatic logic [31:0] rd_mux(ftp_state_t s);
		case (s.addr)
			A_CTRL:  rd_mux = {28'h0, s.ctrl};
			A_SFREQ: rd_mux = {15'h0, s.sfreq};
			A_UPICK: rd_mux = {16'h0, s.upick};
			A_DELAY: rd_mux = {16'h0, s.delay};
			A_STATE: rd_mux = {28'h0, s.volt_ok, s.accepted, s.trip,
			                   s.start};
			A_FREQ:  rd_mux = {15'h0, s.freq};
			A_EVST:  rd_mux = {28'h0, s.ev_stat};
			A_EVMSK: rd_mux = {28'h0, s.ev_mask};
			default: rd_mux = 32'h0;
		endcase
	endfunction : rd_mux

	// Next-state logic for bus, measurement and protection
	always_comb begin
		logic signed [SW-1:0] smp;
		logic [15:0]          mag;
		logic                 neg;
		logic                 rise;
		logic                 fall;
		logic                 launch;
		logic                 veval;
		logic [15:0]          dly;
		logic                 fault;
		smp    = st.ctrl.chan4 ? ch4_sample : ch1_sample;
		mag    = smp[SW-1] ? 16'(-smp) : 16'(smp);
		neg    = smp[SW-1];
		rise   = 1'b0;
		fall   = 1'b0;
		launch = 1'b0;
		veval  = 1'b0;
		dly    = hwdata[15:0];
		fault  = 1'b0;
		beyond = 1'b0;
		run    = st.ctrl.enable && !st.blk_s2;
		n = st;
		n.div_go = 1'b0;

		// Write data phase: zero wait state
		n.wr_pend = 1'b0;
		if (st.wr_pend) begin
			case (st.addr)
				A_CTRL:  n.ctrl = ftp_ctrl_t'(hwdata[3:0]);
				A_SFREQ: n.sfreq = hwdata[FW-1:0];
				A_UPICK: n.upick = hwdata[15:0];
				A_DELAY: begin
					if (dly < DELAY_MIN_MS)
						dly = DELAY_MIN_MS;
					if (dly > DELAY_MAX_MS)
						dly = DELAY_MAX_MS;
					n.delay = dly;
				end
				A_EVST:  n.ev_stat = st.ev_stat & ~hwdata[3:0];
				A_EVMSK: n.ev_mask = hwdata[3:0];
				default: n.addr = st.addr;
			endcase
		end
		// Read data phase: one wait state, then data
		if (st.rd_pend) begin
			n.hrdata  = rd_mux(st);
			n.hready  = 1'b1;
			n.rd_pend = 1'b0;
		end
		// Address phase capture
		if (hsel && htrans[1] && hready) begin
			n.addr = haddr[7:0];
			if (hwrite) begin
				n.wr_pend = 1'b1;
			end else begin
				n.rd_pend = 1'b1;
				n.hready  = 1'b0;
			end
		end

		// Blocking pin synchroniser
		n.blk_s1 = block_input;
		n.blk_s2 = st.blk_s1;

		// Period ages and watchdog
		n.rise_age = age_inc(st.rise_age, P_LIM);
		n.fall_age = age_inc(st.fall_age, P_LIM);
		n.wd       = age_inc(st.wd, P_LIM);
		if (sample_valid) begin
			rise = st.seen && st.sgn_prev && !neg;
			fall = st.seen && !st.sgn_prev && neg;
			n.seen     = 1'b1;
			n.sgn_prev = neg;
			if (mag > st.peak)
				n.peak = mag;
		end
		// Separate periods per crossing direction
		if (rise) begin
			n.p_rise   = st.rise_age;
			n.rise_age = PW'(1); // Crossing cycle counts
			veval      = 1'b1;
		end
		if (fall) begin
			n.p_fall   = st.fall_age;
			n.fall_age = PW'(1); // Crossing cycle counts
		end
		launch = rise || fall;
		if (!launch && st.wd >= P_MAX) begin
			launch = 1'b1;
			veval  = 1'b1;
			n.p_rise = P_LIM;
		end

		// Voltage gate with 0.8 reset ratio, once per cycle
		if (veval) begin
			if (n.peak >= st.upick)
				n.volt_ok = 1'b1;
			else if (20'(n.peak) * DROP_DEN < 20'(st.upick) * DROP_NUM)
				n.volt_ok = 1'b0;
			n.peak = '0;
		end
		if (launch) begin
			n.wd        = '0;
			n.div_go    = 1'b1;
			n.div_valid = per_ok(n.p_rise, P_MIN, P_MAX)
			              && per_ok(n.p_fall, P_MIN, P_MAX)
			              && n.volt_ok;
		end

		// Qualification of each measurement result
		if (res_done) begin
			if (st.div_valid) begin
				n.icnt = '0;
				n.vcnt = cnt_inc(st.vcnt, ACCEPT_N);
				if (n.vcnt == ACCEPT_N) begin
					n.accepted = 1'b1;
					n.freq     = res_quot[FW-1:0];
				end
			end else begin
				n.vcnt = '0;
				n.icnt = cnt_inc(st.icnt, DROP_N);
				if (n.icnt == DROP_N) begin
					n.accepted = 1'b0;
					n.freq     = '0;
				end
			end
			// Threshold comparison on every result
			beyond = n.accepted && st.volt_ok &&
			         (st.ctrl.over ? (n.freq > st.sfreq)
			                       : (n.freq < st.sfreq));
			if (beyond) begin
				n.bcnt = cnt_inc(st.bcnt, START_N);
				if (n.bcnt == START_N)
					n.start = 1'b1;
			end else begin
				n.bcnt = '0;
				if (!st.ctrl.over || !n.accepted || !st.volt_ok ||
				    ({1'b0, n.freq} + HYST_MHZ <= {1'b0, st.sfreq}))
					n.start = 1'b0;
			end
		end

		// Delay timer runs from the first faulty value
		fault = (n.bcnt != '0) || n.start;
		if (fault) begin
			if (st.prescale >= 16'(MS_CYCLES - 1)) begin
				n.prescale = '0;
				if (st.msec != 16'hFFFF)
					n.msec = 16'(st.msec + 16'h0001);
			end else begin
				n.prescale = 16'(st.prescale + 16'h0001);
			end
		end else begin
			n.prescale = '0;
			n.msec     = '0;
		end
		// Trip on expiry while started, dropped with start
		n.trip = (st.trip || (n.msec >= st.delay)) && n.start
		         && !st.ctrl.start_only;

		// Disable and blocking override start, trip, start count and delay timer
		if (!run) begin
			n.start    = 1'b0;
			n.trip     = 1'b0;
			n.bcnt     = '0;
			n.msec     = '0;
			n.prescale = '0;
		end

		// Sticky events, set wins over clear
		if (n.start && !st.start)
			n.ev_stat[EV_ST_ON] = 1'b1;
		if (!n.start && st.start)
			n.ev_stat[EV_ST_OFF] = 1'b1;
		if (n.trip && !st.trip)
			n.ev_stat[EV_TR_ON] = 1'b1;
		if (!n.trip && st.trip)
			n.ev_stat[EV_TR_OFF] = 1'b1;
		n.irq = |(n.ev_stat & n.ev_mask);
	end

	// State register with documented reset values
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st        <= '0;
			st.hready <= 1'b1;
			st.sfreq  <= SFREQ_RST;
			st.upick  <= UPICK_RST;
			st.delay  <= DELAY_RST;
		end else begin
			st <= n;
		end
	end

	// Outputs straight from the state register
	assign hreadyout         = st.hready;
	assign hresp             = st.hresp;
	assign hrdata            = st.hrdata;
	assign general_start_out = st.start;
	assign general_trip_out  = st.trip;
	assign irq               = st.irq;

	// Checks on the protection behaviour
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_good_res;
		res_done && st.div_valid;
	endsequence

	sequence s_bad_res;
		res_done && !st.div_valid;
	endsequence

	chk_accept_four: assert property (
		s_good_res ##0 (st.vcnt == 3'(ACCEPT_N - 3'h1)) |=> st.accepted)
		else $error("frequency not accepted after fourth valid result");

	chk_zero_freq: assert property (
		s_bad_res ##0 (st.icnt == 3'(DROP_N - 3'h1))
		|=> (st.freq == '0) && !st.accepted)
		else $error("frequency not zeroed after fourth invalid result");

	chk_hold_last: assert property (
		s_bad_res ##0 (st.icnt < 3'(DROP_N - 3'h2)) ##0 st.accepted
		|=> st.accepted && (st.freq == $past(st.freq)))
		else $error("last valid frequency not held");

	chk_start_five: assert property (
		res_done && beyond && run && (st.bcnt == 3'(START_N - 3'h1))
		|=> st.start)
		else $error("start missing after fifth value beyond setting");

	chk_start_cause: assert property (
		$rose(st.start) |-> $past(st.bcnt) >= 3'(START_N - 3'h1))
		else $error("start raised before five values");

	chk_over_hyst: assert property (
		st.start && st.ctrl.over && run && res_done && st.volt_ok &&
		st.accepted && st.div_valid && (st.vcnt == ACCEPT_N) &&
		({1'b0, res_quot[FW-1:0]} + HYST_MHZ > {1'b0, st.sfreq})
		|=> st.start)
		else $error("overfrequency start released inside hysteresis");

	chk_trip_delay: assert property (
		$rose(st.trip) |-> st.msec >= st.delay)
		else $error("trip before delay elapsed");

	chk_trip_start: assert property (
		st.trip |-> st.start)
		else $error("trip without start");

	chk_block_quiet: assert property (
		st.blk_s2 |=> !st.start && !st.trip)
		else $error("outputs active while blocked");

	chk_disable_quiet: assert property (
		!st.ctrl.enable |=> !st.start && !st.trip)
		else $error("outputs active while disabled");

	chk_start_only: assert property (
		st.ctrl.start_only |=> !st.trip)
		else $error("trip asserted in start-only mode");

	chk_start_event: assert property (
		$rose(st.start) |-> st.ev_stat[EV_ST_ON])
		else $error("start-on event missing");

	chk_irq_level: assert property (
		st.irq == |(st.ev_stat & st.ev_mask))
		else $error("interrupt level wrong");

	chk_read_wait: assert property (
		hsel && htrans[1] && hready && !hwrite && hreadyout
		|=> !hreadyout ##1 hreadyout)
		else $error("read data phase not one wait state");
endmodule : ftp_top
`default_nettype wire

// file: testbench/ftp_src_model.sv
// Voltage source model: square wave on both channels, sampled sparsely.
// Assumes the bench sets half period and amplitudes off the clock edge.
`timescale 1ns/1ps
`default_nettype none
module ftp_src_model import ftp_pkg::*; (
	// Clock and reset
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	// Wave shape from the bench
	input  wire logic [31:0]           half,
	input  wire logic [15:0]           amp1,
	input  wire logic [15:0]           amp4,
	// Samples towards the block
	output logic                       sample_valid,
	output logic signed [SW-1:0]       ch1_sample,
	output logic signed [SW-1:0]       ch4_sample,
	output logic [31:0]                xings
);
	logic [31:0] ph;
	logic        pos;
	logic [15:0] v1;
	logic [15:0] v4;

	// Phase counter, flips sign each half period, one sample per 10 cycles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph <= '0;
			pos <= 1'b1;
			xings <= '0;
			sample_valid <= 1'b0;
		end else begin
			sample_valid <= (ph % 32'hA) == 32'h0;
			if (ph + 32'h1 >= half) begin
				ph <= '0;
				pos <= !pos;
				xings <= xings + 32'h1;
			end else begin
				ph <= ph + 32'h1;
			end
		end
	end

	// Between samples the lines show the inverse, never a stale value
	assign v1 = pos ? amp1 : 16'(16'h0 - amp1);
	assign v4 = pos ? amp4 : 16'(16'h0 - amp4);
	assign ch1_sample = sample_valid ? $signed(v1) : $signed(~v1);
	assign ch4_sample = sample_valid ? $signed(v4) : $signed(~v4);
endmodule : ftp_src_model
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the frequency protection block.
// Assumes one AHB-Lite slave, so hready is the slave's own hreadyout.
`timescale 1ns/1ps
`default_nettype none
module tb_top import ftp_pkg::*;;
	localparam int RATE  = 25000;
	localparam int MSC   = RATE / 1000;
	localparam int LIMIT = 32'h13880;
	logic                 hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic                 sample_valid, block_input, irq;
	logic                 general_start_out, general_trip_out;
	logic [31:0]          haddr, hwdata, hrdata, half, xings, rd;
	logic [1:0]           htrans;
	logic [2:0]           hsize;
	logic [15:0]          amp1, amp4;
	logic signed [SW-1:0] ch1_sample, ch4_sample;
	int                   miscompares, comparisons, cyc, seed, s;
	int                   xt [$];
	logic [7:0]           addrs [9];
	logic [31:0]          rstv [9];

	ftp_top #(.MS_CYCLES(MSC), .CLK_RATE(RATE)) dut (.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.sample_valid(sample_valid), .ch1_sample(ch1_sample),
		.ch4_sample(ch4_sample), .block_input(block_input),
		.general_start_out(general_start_out),
		.general_trip_out(general_trip_out), .irq(irq));
	ftp_src_model src (.hclk(hclk), .hresetn(hresetn), .half(half),
		.amp1(amp1), .amp4(amp4), .sample_valid(sample_valid),
		.ch1_sample(ch1_sample), .ch4_sample(ch4_sample), .xings(xings));

	// Clock of 40 ns period
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	// Verdict and end of run
	task automatic report_and_stop;
		if (miscompares == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop

	// Cut a hang short
	always @(posedge hclk) begin
		cyc++;
		if (cyc > LIMIT) begin
			miscompares++;
			report_and_stop();
		end
	end

	// Compare one result, four-state exact
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One single-word AHB transfer; read data lands in rd
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	// Measurement model: cycle of each of the last four crossings
	always @(xings) begin
		xt.push_back(cyc);
		if (xt.size() > 4)
			void'(xt.pop_front());
	end

	// Expected mHz from the mean of the latest rising and falling periods
	function automatic logic [31:0] fmodel();
		int mean;
		mean = (xt[3] - xt[1] + xt[2] - xt[0]) / 2;
		fmodel = (xt.size() < 4 || mean <= 0) ? 32'h0
		         : 32'((64'(RATE) * 64'h3E8) / 64'(mean));
	endfunction : fmodel

	// Wait n crossings plus the result latency
	task automatic wait_x(input int n);
		s = xings;
		while (xings < s + n) @(posedge hclk);
		repeat (45) @(posedge hclk);
	endtask : wait_x

	// Wait for start to reach v, at most n crossings
	task automatic wait_start(input logic v, input int n);
		s = xings;
		while (general_start_out !== v && xings < s + n) @(posedge hclk);
	endtask : wait_start

	// Main sequence
	initial begin
		seed = 32'h3dcf;
		{hsel, hwrite, htrans, haddr, hwdata, block_input} = '0;
		hsize = 3'h2;
		half = 32'hFA;
		amp1 = 16'(16'h3E80 + ($random(seed) & 32'hFFF));
		amp4 = 16'h0;
		hresetn = 1'b0;
		addrs = '{A_CTRL, A_SFREQ, A_UPICK, A_DELAY, A_STATE, A_FREQ,
			A_EVST, A_EVMSK, 8'h20};
		rstv = '{32'h0, 32'(SFREQ_RST), 32'(UPICK_RST), 32'(DELAY_RST),
			32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		// Reset values, unmapped space, read-only and clamped writes
		foreach (addrs[i]) begin
			bus(1'b0, addrs[i], 32'h0);
			chk(rd, rstv[i]);
		end
		bus(1'b1, 8'h20, 32'h5);
		bus(1'b1, A_FREQ, 32'h1234);
		bus(1'b0, A_FREQ, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, A_DELAY, 32'h1);
		bus(1'b0, A_DELAY, 32'h0);
		chk(rd, 32'(DELAY_MIN_MS));
		bus(1'b1, A_DELAY, 32'hFFFF);
		bus(1'b0, A_DELAY, 32'h0);
		chk(rd, 32'(DELAY_MAX_MS));
		bus(1'b1, A_DELAY, 32'h8C);
		bus(1'b1, A_EVMSK, 32'hF);
		bus(1'b1, A_SFREQ, 32'hC738);
		bus(1'b1, A_CTRL, 32'h7);
		// One second of nominal pre-fault, frequency accepted
		wait_x(100);
		bus(1'b0, A_FREQ, 32'h0);
		chk(rd, fmodel());
		bus(1'b0, A_STATE, 32'h0);
		chk(rd, 32'hC);
		// Overfrequency fault with start only
		half <= 32'hC8;
		wait_start(1'b1, 12);
		chk(32'(general_start_out), 32'h1);
		chk(32'(xings - s >= 5), 32'h1);
		repeat (4000) @(posedge hclk);
		chk(32'(general_trip_out), 32'h0);
		bus(1'b0, A_FREQ, 32'h0);
		chk(rd, fmodel());
		// Trip delay already run out since the onset
		bus(1'b1, A_CTRL, 32'h3);
		repeat (4) @(posedge hclk);
		chk(32'(general_trip_out), 32'h1);
		bus(1'b0, A_EVST, 32'h0);
		chk(rd, 32'h5);
		chk(32'(irq), 32'h1);
		bus(1'b1, A_EVMSK, 32'h0);
		repeat (2) @(posedge hclk);
		chk(32'(irq), 32'h0);
		bus(1'b1, A_EVMSK, 32'hF);
		bus(1'b1, A_EVST, 32'h5);
		repeat (2) @(posedge hclk);
		chk(32'(irq), 32'h0);
		bus(1'b0, A_STATE, 32'h0);
		chk(rd, 32'hF);
		// Blocking input
		@(posedge hclk);
		block_input <= 1'b1;
		repeat (4) @(posedge hclk);
		chk(32'({general_start_out, general_trip_out}), 32'h0);
		bus(1'b0, A_EVST, 32'h0);
		chk(rd, 32'hA);
		block_input <= 1'b0;
		bus(1'b1, A_EVST, 32'hA);
		wait_start(1'b1, 12);
		chk(32'(general_start_out), 32'h1);
		// Release hysteresis at its boundary
		bus(1'b1, A_SFREQ, 32'hF488);
		wait_x(3);
		chk(32'(general_start_out), 32'h1);
		bus(1'b1, A_SFREQ, 32'hF489);
		wait_x(2);
		chk(32'({general_start_out, general_trip_out}), 32'h0);
		// Underfrequency mode
		bus(1'b1, A_SFREQ, 32'hF618);
		bus(1'b1, A_CTRL, 32'h1);
		wait_x(3);
		chk(32'(general_start_out), 32'h0);
		wait_start(1'b1, 6);
		chk(32'(general_start_out), 32'h1);
		bus(1'b1, A_CTRL, 32'h0);
		repeat (2) @(posedge hclk);
		chk(32'({general_start_out, general_trip_out}), 32'h0);
		// Busbar channel: gate held above 0.8 of pickup, then dropped
		amp4 <= 16'h36B0;
		bus(1'b1, A_CTRL, 32'h8);
		wait_x(4);
		bus(1'b0, A_FREQ, 32'h0);
		chk(rd, fmodel());
		amp4 <= 16'h2AF8;
		wait_x(10);
		bus(1'b0, A_FREQ, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, A_STATE, 32'h0);
		chk(rd, 32'h0);
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
